// [hdl/pcs_core_regs.sv]
// core registers: timer, paged program counter, status, RAM pointer and data RAM
`timescale 1ns/10ps
`include "pcs_params.svh"
module pcs_core_regs (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// avalon-mm slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [7:0] writedata,
	output logic [7:0] readdata,
	output logic waitrequest,
	// external counter pin
	input wire logic timerPin,
	// execution side
	input wire logic [3:0] cmdCode,
	input wire logic cmdValid,
	input wire logic [9:0] cmdOperand,
	input wire logic [7:0] accValue,
	input wire logic [2:0] flagsIn,
	input wire logic flagsValid,
	// status out
	output logic [12:0] progAddr,
	output logic [7:0] statusOut
);
	typedef struct packed {
		logic [7:0] timer;
		logic [12:0] pc;
		logic [7:0] status;
		logic [7:0] pointer;
		logic [7:0] control;
		logic [2:0] sp;
		logic [2:0] pinSync;
		logic pinLevel;
		logic [1:0] latency;
		pcs_pkg::pcs_bus_t bus;
		logic [7:0] rdata;
		logic wait_;
		logic [9:0] operand;
		logic sleeping;
	} pcs_state_t;

	pcs_state_t st_ff;
	pcs_state_t nxt_st;
	logic [12:0] stack_ff [`PCS_STACK_DEPTH];
	logic [7:0] ram_ff [`PCS_RAM_WORDS];
	logic pushEn;
	logic [2:0] pushIdx;
	logic [12:0] pushVal;
	logic ramWe;
	logic [7:0] ramIdx;
	logic [7:0] ramWdata;

	// ram index for an address; bank from pointer bits 7..6
	function automatic logic [7:0] ramIndex(input logic [5:0] a, input logic [1:0] bank);
		logic [7:0] idx;
		idx = 8'h00;
		if (a < `PCS_ADDR_BANKED_LO) begin
			idx = {2'h0, a} - 8'h10; // RULE_18
		end else begin
			idx = 8'h10 + {1'b0, bank, a[4:0]}; // RULE_18 RULE_20
		end
		return idx;
	endfunction

	// page bits for counter top; page 4 ignores low select bits
	function automatic logic [2:0] pageBits(input logic [2:0] ps);
		return ps[2] ? 3'h4 : ps; // RULE_11
	endfunction

	// operand load into a page, used by jump and call
	function automatic logic [12:0] pagedLoad(input logic [2:0] ps, input logic [9:0] op);
		return {pageBits(ps), op}; // RULE_05 RULE_10
	endfunction

	logic [7:0] busAddr;
	logic [5:0] effAddr;
	logic isRam;
	logic pinEdge;

	always_comb begin
		nxt_st = st_ff;
		pushEn = 1'b0;
		pushIdx = st_ff.sp;
		pushVal = st_ff.pc + 13'h0001;
		ramWe = 1'b0;
		ramWdata = writedata;
		busAddr = address;
		// indirect access resolves through the pointer
		effAddr = (address == `PCS_ADDR_INDIRECT) ? st_ff.pointer[5:0] : address[5:0]; // RULE_01 RULE_19
		isRam = (busAddr < 8'h40) && (effAddr >= `PCS_ADDR_COMMON_LO);
		ramIdx = ramIndex(effAddr, st_ff.pointer[7:6]);
		// pin passes three flops; edge once second and third agree
		nxt_st.pinSync = {st_ff.pinSync[1:0], timerPin};
		pinEdge = 1'b0;
		if (st_ff.pinSync[2] == st_ff.pinSync[1] && st_ff.pinSync[2] != st_ff.pinLevel) begin
			nxt_st.pinLevel = st_ff.pinSync[2];
			pinEdge = st_ff.pinSync[2] ^ st_ff.control[1];
		end
		// control bit 0 picks pin source, bit 1 picks falling edge
		if (st_ff.control[0] ? pinEdge : 1'b1) begin
			nxt_st.timer = st_ff.timer + 8'h01; // RULE_02
		end
		if (flagsValid) begin
			nxt_st.status[2:0] = flagsIn; // RULE_17
		end
		// execution commands
		if (cmdValid) begin
			case (pcs_pkg::pcs_cmd_t'(cmdCode))
				pcs_pkg::CMD_STEP: nxt_st.pc = st_ff.pc + 13'h0001; // RULE_21
				pcs_pkg::CMD_JUMP: nxt_st.pc = pagedLoad(st_ff.status[7:5], cmdOperand); // RULE_05
				pcs_pkg::CMD_CALL: begin
					pushEn = 1'b1; // RULE_06
					nxt_st.sp = st_ff.sp + 3'h1;
					nxt_st.pc = pagedLoad(st_ff.status[7:5], cmdOperand); // RULE_06
				end
				pcs_pkg::CMD_RET: begin
					nxt_st.sp = st_ff.sp - 3'h1;
					nxt_st.pc = stack_ff[st_ff.sp - 3'h1]; // RULE_07 RULE_13
				end
				pcs_pkg::CMD_ADDPC: begin
					nxt_st.pc = st_ff.pc + {5'h00, accValue}; // RULE_08
				end
				pcs_pkg::CMD_MOVPC: begin
					nxt_st.pc = {pageBits(st_ff.status[7:5]), st_ff.pc[9:8], accValue}; // RULE_09 RULE_10
				end
				pcs_pkg::CMD_PAGE: begin
					nxt_st.status[7:5] = cmdOperand[2:0]; // RULE_12
					nxt_st.pc = st_ff.pc + 13'h0001;
				end
				pcs_pkg::CMD_SLEEP: begin
					nxt_st.status[`PCS_BIT_TIMEOUT] = 1'b1; // RULE_14
					nxt_st.status[`PCS_BIT_PWRDN] = 1'b0; // RULE_15
					nxt_st.sleeping = 1'b1;
					nxt_st.pc = st_ff.pc + 13'h0001;
				end
				pcs_pkg::CMD_WDTCLR: begin
					nxt_st.status[`PCS_BIT_TIMEOUT] = 1'b1; // RULE_14
					nxt_st.status[`PCS_BIT_PWRDN] = 1'b1; // RULE_15
					// an executing instruction proves the core is awake
					nxt_st.sleeping = 1'b0;
					nxt_st.pc = st_ff.pc + 13'h0001;
				end
				pcs_pkg::CMD_WDTOUT: begin
					// sleeping wake gives 00, awake timeout gives 01
					nxt_st.status[`PCS_BIT_TIMEOUT] = 1'b0; // RULE_14 RULE_16
					nxt_st.status[`PCS_BIT_PWRDN] = ~st_ff.sleeping; // RULE_16
					nxt_st.sleeping = 1'b0;
					if (!st_ff.sleeping) begin
						nxt_st.pc = 13'h0000;
					end
				end
				pcs_pkg::CMD_PINWAKE: begin
					// pin wake from sleep gives 10, pin pulse while awake gives 11
					nxt_st.status[`PCS_BIT_TIMEOUT] = 1'b1; // RULE_16
					nxt_st.status[`PCS_BIT_PWRDN] = ~st_ff.sleeping; // RULE_16
					nxt_st.sleeping = 1'b0;
					nxt_st.pc = 13'h0000; // RULE_04
				end
				default: begin
				end
			endcase
		end
		// bus slave: fixed latency, then one done cycle
		nxt_st.wait_ = 1'b1;
		case (st_ff.bus)
			pcs_pkg::BUS_IDLE: begin
				if (read || write) begin
					nxt_st.bus = pcs_pkg::BUS_WAIT;
					nxt_st.latency = `PCS_BUS_LAT;
				end
			end
			pcs_pkg::BUS_WAIT: begin
				if (st_ff.latency != 2'h0) begin
					nxt_st.latency = st_ff.latency - 2'h1;
				end else begin
					nxt_st.bus = pcs_pkg::BUS_DONE;
					nxt_st.wait_ = 1'b0;
					nxt_st.rdata = 8'h00;
					if (isRam) begin
						nxt_st.rdata = ram_ff[ramIdx]; // RULE_18
						ramWe = write;
					end else begin
						case (effAddr)
							6'h00: nxt_st.rdata = 8'h00;
							6'h01: nxt_st.rdata = st_ff.timer; // RULE_02
							6'h02: nxt_st.rdata = st_ff.pc[7:0];
							6'h03: nxt_st.rdata = st_ff.status;
							6'h04: nxt_st.rdata = st_ff.pointer;
							6'h05: nxt_st.rdata = {3'h0, st_ff.pc[12:8]};
							6'h06: nxt_st.rdata = st_ff.control;
							6'h08: nxt_st.rdata = {3'h0, stack_ff[st_ff.sp - 3'h1][12:8]};
							6'h09: nxt_st.rdata = {5'h00, st_ff.sp};
							6'h0A: nxt_st.rdata = st_ff.operand[7:0];
							default: nxt_st.rdata = 8'h00;
						endcase
						if (write && busAddr < 8'h40) begin
							case (effAddr)
								6'h01: nxt_st.timer = writedata; // RULE_02
								6'h02: nxt_st.pc = {pageBits(st_ff.status[7:5]), st_ff.pc[9:8], writedata}; // RULE_10
								6'h03: nxt_st.status = writedata; // RULE_12 RULE_17
								6'h04: nxt_st.pointer = writedata; // RULE_19 RULE_20
								6'h06: nxt_st.control = writedata;
								6'h0A: nxt_st.operand = {2'h0, writedata};
								default: begin
								end
							endcase
						end
					end
				end
			end
			pcs_pkg::BUS_DONE: nxt_st.bus = pcs_pkg::BUS_IDLE;
			default: nxt_st.bus = pcs_pkg::BUS_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			st_ff <= '0;
			st_ff.status <= `PCS_STATUS_RESET; // RULE_14 RULE_15 RULE_16
			st_ff.pointer <= `PCS_POINTER_RESET;
			st_ff.pc <= 13'h0000; // RULE_04
			st_ff.wait_ <= 1'b1;
			st_ff.bus <= pcs_pkg::BUS_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// storage arrays hold no control state, so they take no reset
	always_ff @(posedge clock) begin
		if (pushEn) begin
			stack_ff[pushIdx] <= pushVal; // RULE_06
		end
		if (ramWe) begin
			ram_ff[ramIdx] <= ramWdata;
		end
	end

	assign readdata = st_ff.rdata;
	assign waitrequest = st_ff.wait_;
	assign progAddr = st_ff.pc; // RULE_03
	assign statusOut = st_ff.status;
endmodule

// [include/pcs_params.svh]
// constants and behaviour notes for the core status and program counter block
// Notes on behaviour
// RULE_01: address zero has no storage; accesses go to location chosen by RAM pointer.
// RULE_02: timer counter counts external edges or instruction cycles; program reads/writes it.
// RULE_03: program counter is 13 bits, addressing 8K words.
// RULE_04: program counter clears to zero on reset.
// RULE_05: jump loads operand into lower 10 counter bits.
// RULE_06: call pushes next address and loads operand into lower 10 bits.
// RULE_07: every return reloads the counter from top of stack.
// RULE_08: adding accumulator to counter is a full add with carry upward.
// RULE_09: moving accumulator to counter replaces low 8 bits, keeps bits 8 and 9.
// RULE_10: counter-writing instructions copy page select into bits 10 to 12.
// RULE_11: page select sits in status 7..5; top bit set selects page 4.
// RULE_12: page select changes by page instruction or status register write.
// RULE_13: returns leave page select alone; stack address alone gives page.
// RULE_14: time-out flag set by sleep, watchdog clear, power-up; cleared by timeout.
// RULE_15: power-down flag set at power-on and watchdog clear; cleared by sleep.
// RULE_16: flag pair reads 00,01,10,11 after the four wake and reset events.
// RULE_17: status bits 2,1,0 are zero, half carry and carry flags.
// RULE_18: addresses 10h-1Fh common; 20h-3Fh in one of four banked 32-byte areas.
// RULE_19: pointer low six bits give indirect address; otherwise a plain byte.
// RULE_20: pointer bits 7 and 6 select the active data bank.
// RULE_21: non-branching instructions advance the counter by one, page select untouched.
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH
`define PCS_ADDR_INDIRECT 8'h00
`define PCS_ADDR_TIMER 8'h01
`define PCS_ADDR_PCLOW 8'h02
`define PCS_ADDR_STATUS 8'h03
`define PCS_ADDR_POINTER 8'h04
`define PCS_ADDR_PCHIGH 8'h05
`define PCS_ADDR_CONTROL 8'h06
`define PCS_ADDR_CMD 8'h07
`define PCS_ADDR_STKTOP 8'h08
`define PCS_ADDR_STKSET 8'h09
`define PCS_ADDR_OPERAND 8'h0A
`define PCS_ADDR_COMMON_LO 6'h10
`define PCS_ADDR_BANKED_LO 6'h20
`define PCS_PC_WIDTH 13
`define PCS_STACK_DEPTH 8
`define PCS_RAM_WORDS 144
`define PCS_BIT_TIMEOUT 4
`define PCS_BIT_PWRDN 3
`define PCS_BIT_ZERO 2
`define PCS_BIT_HALF 1
`define PCS_BIT_CARRY 0
`define PCS_PAGE_LSB 5
`define PCS_STATUS_RESET 8'h18
`define PCS_POINTER_RESET 8'h00
`define PCS_BUS_LAT 2'h1
`endif

// [include/pcs_pkg.sv]
// types for the core status and program counter block
package pcs_pkg;
	typedef enum logic [3:0] {
		CMD_NONE, CMD_STEP, CMD_JUMP, CMD_CALL, CMD_RET, CMD_ADDPC, CMD_MOVPC,
		CMD_PAGE, CMD_SLEEP, CMD_WDTCLR, CMD_WDTOUT, CMD_PINWAKE
	} pcs_cmd_t;
	typedef enum logic [1:0] {
		BUS_IDLE, BUS_WAIT, BUS_DONE
	} pcs_bus_t;
endpackage

// [verif/pcs_exec_model.sv]
// execute-side model: issues one command or flag load at a time
`timescale 1ns/10ps
module pcs_exec_model (
	// clock
	input wire logic clock,
	// command and flag outputs
	output logic [3:0] cmdCode,
	output logic cmdValid,
	output logic [9:0] cmdOperand,
	output logic [7:0] accValue,
	output logic [2:0] flagsIn,
	output logic flagsValid
);
	initial {cmdCode, cmdValid, cmdOperand, accValue, flagsIn, flagsValid} = '0;
	// code zero is an alu result; operand low bits double as accumulator
	task automatic issue(input logic [3:0] c, input logic [9:0] o);
		@(posedge clock);
		cmdCode <= c;
		cmdValid <= c != 4'h0;
		cmdOperand <= o;
		accValue <= o[7:0];
		flagsIn <= o[2:0];
		flagsValid <= c == 4'h0;
		@(posedge clock);
		cmdValid <= 1'b0;
		flagsValid <= 1'b0;
		// stale qualified lines must not look valid
		cmdOperand <= ~o;
		accValue <= ~o[7:0];
		#1;
	endtask
endmodule

// [verif/pcs_core_regs_checker.sv]
// port assertions for the core register block
`timescale 1ns/10ps
module pcs_core_regs_checker (
	// clock, reset and bus
	input wire logic clock,
	input wire logic resetn,
	input wire logic write,
	// execute side
	input wire logic [3:0] cmdCode,
	input wire logic cmdValid,
	input wire logic [9:0] cmdOperand,
	input wire logic [7:0] accValue,
	input wire logic [2:0] flagsIn,
	input wire logic flagsValid,
	input wire logic [12:0] progAddr,
	input wire logic [7:0] statusOut
);
	logic [2:0] pg;
	logic go;
	assign pg = statusOut[7] ? 3'h4 : statusOut[7:5];
	// a bus write in the same cycle wins over the command
	assign go = cmdValid && !write;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_rst; $rose(resetn) |-> progAddr == 13'h0 && statusOut == 8'h18; endproperty
	a_rst: assert property (p_rst) else $error("reset values");
	property p_step; go && cmdCode == 4'h1 |=> progAddr == $past(progAddr) + 13'h1; endproperty
	a_step: assert property (p_step) else $error("step");
	property p_jmp;
		go && cmdCode inside {4'h2, 4'h3} |=> progAddr == {$past(pg), $past(cmdOperand)};
	endproperty
	a_jmp: assert property (p_jmp) else $error("jump target");
	property p_ret;
		go && cmdCode == 4'h3 ##2 go && cmdCode == 4'h4 |=> progAddr == $past(progAddr, 3) + 13'h1;
	endproperty
	a_ret: assert property (p_ret) else $error("return address");
	property p_mov;
		go && cmdCode == 4'h6 |=> progAddr == {$past(pg), $past(progAddr[9:8]), $past(accValue)};
	endproperty
	a_mov: assert property (p_mov) else $error("move to pc");
	property p_pg; go && cmdCode == 4'h7 |=> statusOut[7:5] == $past(cmdOperand[2:0]); endproperty
	a_pg: assert property (p_pg) else $error("page select");
	property p_tp;
		go && cmdCode inside {4'h8, 4'h9} |=> statusOut[4:3] == {1'b1, $past(cmdCode[0])};
	endproperty
	a_tp: assert property (p_tp) else $error("time-out pair");
	property p_flg; flagsValid && !write |=> statusOut[2:0] == $past(flagsIn); endproperty
	a_flg: assert property (p_flg) else $error("alu flags");
endmodule

// [verif/pcs_core_regs_tb.sv]
// self-checking bench for the core register block
`timescale 1ns/10ps
module pcs_core_regs_tb;
	logic clock = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0, timerPin = 1'b0;
	logic [7:0] address = 8'h0, writedata = 8'h0, readdata, accValue, statusOut, q;
	logic waitrequest, cmdValid, flagsValid;
	logic [3:0] cmdCode;
	logic [9:0] cmdOperand;
	logic [2:0] flagsIn;
	logic [12:0] progAddr;
	int fails = 0, num_checks = 0;
	pcs_core_regs dut (.clock(clock), .resetn(resetn), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.timerPin(timerPin), .cmdCode(cmdCode), .cmdValid(cmdValid), .cmdOperand(cmdOperand),
		.accValue(accValue), .flagsIn(flagsIn), .flagsValid(flagsValid), .progAddr(progAddr),
		.statusOut(statusOut));
	pcs_exec_model cpu (.clock(clock), .cmdCode(cmdCode), .cmdValid(cmdValid),
		.cmdOperand(cmdOperand), .accValue(accValue), .flagsIn(flagsIn), .flagsValid(flagsValid));
	initial forever #5 clock = ~clock;
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [12:0] g, input logic [12:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n = 0;
		@(posedge clock);
		address <= a;
		writedata <= d;
		read <= !w;
		write <= w;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (waitrequest !== 1'b0) begin
			fails++;
			wrap_up();
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	// command, then expected pc and masked status
	task automatic s(input logic [3:0] c, input logic [9:0] o, input logic [12:0] pc,
			input logic [7:0] st, input logic [7:0] m = 8'hFF);
		cpu.issue(c, o);
		chk(progAddr, pc);
		chk(statusOut & m, st);
	endtask
	task automatic t_cmd;
		s(4'h0, 10'h5, 13'h0, 8'h1D);
		s(4'h7, 10'h2, 13'h1, 8'h5D);
		s(4'h2, 10'h155, 13'h955, 8'h5D);
		s(4'h3, 10'h3FF, 13'hBFF, 8'h5D);
		s(4'h4, 10'h0, 13'h956, 8'h5D);
		s(4'h3, 10'h200, 13'hA00, 8'h5D);
		s(4'h7, 10'h5, 13'hA01, 8'hBD);
		s(4'h4, 10'h0, 13'h957, 8'hBD);
		s(4'h2, 10'h1, 13'h1001, 8'hBD);
		s(4'h7, 10'h1, 13'h1002, 8'h3D);
		s(4'h6, 10'hF0, 13'h4F0, 8'h3D);
		s(4'h5, 10'h20, 13'h510, 8'h3D);
		s(4'h1, 10'h0, 13'h511, 8'h3D);
		s(4'h8, 10'h0, 13'h512, 8'h35);
		s(4'h9, 10'h0, 13'h513, 8'h3D);
		s(4'hA, 10'h0, 13'h0, 8'h08, 8'h18);
		s(4'h8, 10'h0, 13'h1, 8'h10, 8'h18);
		s(4'hB, 10'h0, 13'h0, 8'h10, 8'h18);
		s(4'h8, 10'h0, 13'h1, 8'h10, 8'h18);
		cpu.issue(4'hA, 10'h0);
		chk(statusOut[4:3], 13'h0);
		$display("command test done");
	endtask
	task automatic t_bus;
		bus(1'b1, 8'h04, 8'h70);
		bus(1'b1, 8'h00, 8'hA5);
		bus(1'b1, 8'h04, 8'h30);
		bus(1'b1, 8'h00, 8'h5A);
		bus(1'b1, 8'h04, 8'h70);
		bus(1'b0, 8'h00, 8'h00);
		chk(q, 8'hA5);
		bus(1'b0, 8'h04, 8'h00);
		chk(q, 8'h70);
		bus(1'b1, 8'h04, 8'hD0);
		bus(1'b1, 8'h00, 8'h3C);
		bus(1'b0, 8'h10, 8'h00);
		chk(q, 8'h3C);
		bus(1'b0, 8'h40, 8'h00);
		chk(q, 8'h00);
		bus(1'b1, 8'h06, 8'h01);
		bus(1'b1, 8'h01, 8'h80);
		// three rising pin edges, slow enough for the synchroniser
		repeat (6) begin
			repeat (5) @(posedge clock);
			timerPin <= ~timerPin;
		end
		bus(1'b0, 8'h01, 8'h00);
		chk(q, 8'h83);
		$display("bus test done");
	endtask
	initial begin
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		bus(1'b0, 8'h03, 8'h00);
		chk(q, 8'h18);
		chk(progAddr, 13'h0);
		t_cmd();
		t_bus();
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		#1 chk(progAddr, 13'h0);
		wrap_up();
	end
endmodule
bind pcs_core_regs pcs_core_regs_checker chk_i (.clock(clock), .resetn(resetn), .write(write),
	.cmdCode(cmdCode), .cmdValid(cmdValid), .cmdOperand(cmdOperand), .accValue(accValue),
	.flagsIn(flagsIn), .flagsValid(flagsValid), .progAddr(progAddr), .statusOut(statusOut));
